//--- design/cirs_consts.svh
`ifndef CIRS_CONSTS_SVH
`define CIRS_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and pin timing.
// ----------------------------------------------------------------
`define CIRS_CLK_NS          5
`define CIRS_SHORT_NS        15
`define CIRS_MEDIUM_NS       30
`define CIRS_LONG_NS         45
`define CIRS_HIGH_NS         5
`define CIRS_CYC(ns)         (((ns) + `CIRS_CLK_NS - 1) / `CIRS_CLK_NS)
`define CIRS_TIMER_W         4

// ----------------------------------------------------------------
// Software register offsets.
// ----------------------------------------------------------------
`define CIRS_ADDR_W          8
`define CIRS_OFS_CMD         8'h00
`define CIRS_OFS_CONFIG      8'h04
`define CIRS_OFS_STATE       8'h08
`define CIRS_OFS_READ_WORD   8'h0C
`define CIRS_OFS_STATUS      8'h10
`define CIRS_OFS_DECODE      8'h14

// ----------------------------------------------------------------
// Command and configuration register fields.
// ----------------------------------------------------------------
`define CIRS_CMD_WORD_HI     15
`define CIRS_CMD_KIND_HI     17
`define CIRS_CMD_KIND_LO     16
`define CIRS_CMD_MEM         18
`define CIRS_CMD_LAST        19
`define CIRS_CFG_NFA_VALID   0
`define CIRS_CFG_HMA_VALID   1
`define CIRS_CFG_SLOW        2
`define CIRS_CFG_W           3

// ----------------------------------------------------------------
// Opcodes and opcode fields.
// ----------------------------------------------------------------
`define CIRS_OP_GROUP_TCO    8'h02
`define CIRS_OP_GROUP_MOV    8'h03
`define CIRS_OP_GROUP_VBC    8'h04
`define CIRS_OP_GROUP_CMP    8'h05
`define CIRS_OP_GROUP_SPECL  8'h06
`define CIRS_OP_GROUP_FULL   8'h07
`define CIRS_OP_GROUP_MOVA   8'h0B
`define CIRS_OP_GROUP_VBCA   8'h0C
`define CIRS_OP_CMP_VALID    16'h0504
`define CIRS_OP_CMP_RANDOM   16'h0507
`define CIRS_OP_SHIFT_KEY_R  16'h0600
`define CIRS_OP_SHIFT_KEY_L  16'h0601
`define CIRS_OP_SHIFT_M2_R   16'h0610
`define CIRS_OP_SHIFT_M2_L   16'h0611
`define CIRS_OP_FRONT_SET    16'h0618
`define CIRS_OP_BACK_SET     16'h0619
`define CIRS_OP_SEG_RESTORE  16'h061A
`define CIRS_OP_FORCE_FULL   16'h0700
`define CIRS_OP_TCO_CT       16'h0200
`define CIRS_OP_TCO_CT_RST   16'h0201
`define CIRS_MOV_MEM_DST     5
`define CIRS_MOV_MEM_SRC     2

// ----------------------------------------------------------------
// Status word fields.
// ----------------------------------------------------------------
`define CIRS_ST_FULL_N       31
`define CIRS_ST_MULTI_N      30
`define CIRS_ST_VAL_HI       29
`define CIRS_ST_VAL_LO       28
`define CIRS_ST_HIT_N        0

`endif

//--- design/cirs_pkg.sv
package cirs_pkg;

  typedef enum logic [1:0] {
    CIRS_SHORT  = 2'h0,
    CIRS_MEDIUM = 2'h1,
    CIRS_LONG   = 2'h2
  } cirs_class_t;

  typedef enum logic [1:0] {
    CIRS_CMD_WRITE  = 2'h0,
    CIRS_DATA_WRITE = 2'h1,
    CIRS_CMD_READ   = 2'h2,
    CIRS_DATA_READ  = 2'h3
  } cirs_kind_t;

  typedef enum logic [3:0] {
    CIRS_IDLE  = 4'b0001,
    CIRS_SETUP = 4'b0010,
    CIRS_LOW   = 4'b0100,
    CIRS_HIGH  = 4'b1000
  } cirs_state_t;

endpackage : cirs_pkg

//--- design/cirs_ce_timer.sv
`timescale 1ns/100ps
`include "cirs_consts.svh"

module cirs_ce_timer
  import cirs_pkg::*;
#(
  parameter int WIDTH = `CIRS_TIMER_W
) (
  // Clock and reset.
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  // Load and expiry.
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_count,
  output logic                  o_done
);

  initial begin
    if (WIDTH < 2) begin
      $error("cirs_ce_timer: WIDTH too small");
    end
  end

  logic [WIDTH-1:0] count;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= '0;
    end else if (i_load) begin
      count <= i_count;
    end else if (count != '0) begin
      count <= count - WIDTH'(1);
    end
  end

  assign o_done = (count == WIDTH'(1));

endmodule : cirs_ce_timer

//--- design/cirs_cycle_class.sv
`timescale 1ns/100ps
`include "cirs_consts.svh"

module cirs_cycle_class
  import cirs_pkg::*;
(
  // Transfer being started.
  input  wire cirs_kind_t  i_kind,
  input  wire logic [15:0] i_word,
  input  wire logic        i_mem,
  input  wire logic        i_last,
  // Pending first half of a two-cycle command.
  input  wire logic        i_second,
  input  wire logic [15:0] i_saved_op,
  // Device knowledge held by software.
  input  wire logic        i_nfa_valid,
  input  wire logic        i_hma_valid,
  input  wire logic        i_slow,
  // Result.
  output cirs_class_t      o_class,
  output logic             o_two_cycle
);

  // --------------------------------------------------------------
  // Opcode classification.
  // --------------------------------------------------------------
  function automatic logic two_cycle_op(input logic [15:0] op);
    two_cycle_op = (op[15:8] == `CIRS_OP_GROUP_TCO) ||
                   (op[15:8] == `CIRS_OP_GROUP_MOVA) ||
                   (op[15:8] == `CIRS_OP_GROUP_VBCA);
  endfunction : two_cycle_op

  function automatic cirs_class_t op_class(input logic [15:0] op, input logic nfa_v,
                                           input logic hma_v, input logic slow);
    op_class = CIRS_SHORT;
    case (op[15:8])
      `CIRS_OP_GROUP_TCO: begin
        if (op == `CIRS_OP_TCO_CT_RST) begin
          op_class = CIRS_MEDIUM;
        end else if (op == `CIRS_OP_TCO_CT && hma_v) begin
          op_class = CIRS_LONG;
        end else begin
          op_class = CIRS_SHORT;
        end
      end
      `CIRS_OP_GROUP_MOV, `CIRS_OP_GROUP_MOVA: begin
        if (op[`CIRS_MOV_MEM_DST]) begin
          op_class = CIRS_LONG;
        end else if (op[`CIRS_MOV_MEM_SRC] || op[15:8] == `CIRS_OP_GROUP_MOVA) begin
          op_class = CIRS_MEDIUM;
        end else if (slow) begin
          op_class = CIRS_MEDIUM;
        end else begin
          op_class = CIRS_SHORT;
        end
      end
      `CIRS_OP_GROUP_VBC, `CIRS_OP_GROUP_VBCA: begin
        op_class = nfa_v ? CIRS_LONG : CIRS_MEDIUM;
      end
      `CIRS_OP_GROUP_CMP: begin
        op_class = CIRS_LONG;
      end
      `CIRS_OP_GROUP_SPECL: begin
        if (op == `CIRS_OP_FRONT_SET || op == `CIRS_OP_BACK_SET || op == `CIRS_OP_SEG_RESTORE) begin
          op_class = CIRS_SHORT;
        end else begin
          op_class = CIRS_MEDIUM;
        end
      end
      `CIRS_OP_GROUP_FULL: begin
        op_class = (op == `CIRS_OP_FORCE_FULL) ? CIRS_LONG : CIRS_SHORT;
      end
      default: begin
        op_class = CIRS_SHORT;
      end
    endcase
  endfunction : op_class

  // --------------------------------------------------------------
  // Class of the transfer.
  // --------------------------------------------------------------
  always_comb begin
    o_two_cycle = 1'b0;
    o_class     = CIRS_SHORT;
    case (i_kind)
      CIRS_CMD_WRITE: begin
        if (i_second) begin
          o_class = op_class(i_saved_op, i_nfa_valid, i_hma_valid, i_slow);
        end else if (two_cycle_op(i_word)) begin
          o_class     = CIRS_SHORT;
          o_two_cycle = 1'b1;
        end else begin
          o_class = op_class(i_word, i_nfa_valid, i_hma_valid, i_slow);
        end
      end
      CIRS_DATA_WRITE: begin
        if (i_mem) begin
          o_class = i_nfa_valid ? CIRS_LONG : CIRS_MEDIUM;
        end else begin
          o_class = i_last ? CIRS_LONG : CIRS_SHORT;
        end
      end
      CIRS_CMD_READ: begin
        o_class = CIRS_MEDIUM;
      end
      CIRS_DATA_READ: begin
        o_class = i_mem ? CIRS_LONG : CIRS_MEDIUM;
      end
      default: begin
        o_class = CIRS_SHORT;
      end
    endcase
  end

endmodule : cirs_cycle_class

//--- design/cirs_host.sv
// What this block does
// - Compare opcodes 0504H-0507H use long cycles.
// - Register moves (medium when slow is set) and selects use short cycles.
// - Memory-to-register moves, logical shifts use medium.
// - Memory writes, compares, 0700H use long cycles.
// - Data writes: last segment long; memory long with NFA valid, else medium.
// - Two-cycle commands: first short, then listed length.
// - Next free location read after its select.
// - Status: low half first, high half next.
`timescale 1ns/100ps
`include "cirs_consts.svh"

module cirs_host
  import cirs_pkg::*;
#(
  parameter int ADDR_W = `CIRS_ADDR_W
) (
  // Clock and reset.
  input  wire logic              i_clock,
  input  wire logic              i_rstn,
  // Software register port.
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [31:0]       o_rdata,
  // Device pins.
  output logic                   o_ce_n,
  output logic                   o_cmd_n,
  output logic                   o_wr_n,
  output logic      [15:0]       o_dq,
  output logic                   o_dq_oe,
  input  wire logic [15:0]       i_dq
);

  initial begin
    if (ADDR_W < `CIRS_ADDR_W) begin
      $error("cirs_host: ADDR_W too small for the register map");
    end
  end

  localparam logic [`CIRS_TIMER_W-1:0] SHORT_CYC  = `CIRS_TIMER_W'(`CIRS_CYC(`CIRS_SHORT_NS));
  localparam logic [`CIRS_TIMER_W-1:0] MEDIUM_CYC = `CIRS_TIMER_W'(`CIRS_CYC(`CIRS_MEDIUM_NS));
  localparam logic [`CIRS_TIMER_W-1:0] LONG_CYC   = `CIRS_TIMER_W'(`CIRS_CYC(`CIRS_LONG_NS));
  localparam logic [`CIRS_TIMER_W-1:0] HIGH_CYC   = `CIRS_TIMER_W'(`CIRS_CYC(`CIRS_HIGH_NS));

  // ----------------------------------------------------------------
  // Reset release.
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  function automatic logic [`CIRS_TIMER_W-1:0] class_cycles(input cirs_class_t c);
    case (c)
      CIRS_SHORT:  class_cycles = SHORT_CYC;
      CIRS_MEDIUM: class_cycles = MEDIUM_CYC;
      CIRS_LONG:   class_cycles = LONG_CYC;
      default:     class_cycles = LONG_CYC;
    endcase
  endfunction : class_cycles

  function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [`CIRS_ADDR_W-1:0] ofs);
    is_addr = (a == ADDR_W'(ofs));
  endfunction : is_addr

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  cirs_state_t            state;
  cirs_kind_t             kind;
  cirs_kind_t             new_kind;
  cirs_class_t            new_class;
  cirs_class_t            cur_class;
  logic [15:0]            cur_word;
  logic [15:0]            saved_op;
  logic                   second_pending;
  logic                   new_two_cycle;
  logic                   status_pair;
  logic                   status_high;
  logic [`CIRS_CFG_W-1:0] config_bits;
  logic [15:0]            read_word;
  logic [31:0]            match_status;
  logic                   timer_done;
  logic                   timer_load;
  logic [`CIRS_TIMER_W-1:0] timer_count;
  logic                   cmd_write;
  logic                   start;

  assign new_kind  = cirs_kind_t'(i_wdata[`CIRS_CMD_KIND_HI:`CIRS_CMD_KIND_LO]);
  assign cmd_write = i_wr && is_addr(i_addr, `CIRS_OFS_CMD);
  assign start     = cmd_write && (state == CIRS_IDLE);

  // ----------------------------------------------------------------
  // Cycle length and chip enable timer.
  // ----------------------------------------------------------------
  cirs_cycle_class u_class (
    .i_kind      (new_kind),
    .i_word      (i_wdata[`CIRS_CMD_WORD_HI:0]),
    .i_mem       (i_wdata[`CIRS_CMD_MEM]),
    .i_last      (i_wdata[`CIRS_CMD_LAST]),
    .i_second    (second_pending),
    .i_saved_op  (saved_op),
    .i_nfa_valid (config_bits[`CIRS_CFG_NFA_VALID]),
    .i_hma_valid (config_bits[`CIRS_CFG_HMA_VALID]),
    .i_slow      (config_bits[`CIRS_CFG_SLOW]),
    .o_class     (new_class),
    .o_two_cycle (new_two_cycle)
  );

  assign timer_load  = (state == CIRS_SETUP) || ((state == CIRS_LOW) && timer_done);
  assign timer_count = (state == CIRS_SETUP) ? class_cycles(cur_class) : HIGH_CYC;

  cirs_ce_timer #(
    .WIDTH (`CIRS_TIMER_W)
  ) u_timer (
    .i_clock (i_clock),
    .i_rst_n (rst_n),
    .i_load  (timer_load),
    .i_count (timer_count),
    .o_done  (timer_done)
  );

  // ----------------------------------------------------------------
  // Configuration register.
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      config_bits <= '0;
    end else if (i_wr && is_addr(i_addr, `CIRS_OFS_CONFIG)) begin
      config_bits <= i_wdata[`CIRS_CFG_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer.
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state       <= CIRS_IDLE;
      kind        <= CIRS_CMD_WRITE;
      cur_class   <= CIRS_SHORT;
      cur_word    <= '0;
      status_pair <= 1'b0;
      status_high <= 1'b0;
    end else begin
      case (state)
        CIRS_IDLE: begin
          if (start) begin
            state       <= CIRS_SETUP;
            kind        <= new_kind;
            cur_class   <= new_class;
            cur_word    <= i_wdata[`CIRS_CMD_WORD_HI:0];
            status_pair <= (new_kind == CIRS_CMD_READ) && i_wdata[`CIRS_CMD_MEM];
            status_high <= 1'b0;
          end
        end
        CIRS_SETUP: begin
          state <= CIRS_LOW;
        end
        CIRS_LOW: begin
          if (timer_done) begin
            state <= CIRS_HIGH;
          end
        end
        CIRS_HIGH: begin
          if (timer_done) begin
            if (status_pair && !status_high) begin
              state       <= CIRS_SETUP;
              status_high <= 1'b1;
            end else begin
              state <= CIRS_IDLE;
            end
          end
        end
        default: begin
          state <= CIRS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Two-cycle command tracking.
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      second_pending <= 1'b0;
      saved_op       <= '0;
    end else if (start && new_kind == CIRS_CMD_WRITE) begin
      if (second_pending) begin
        second_pending <= 1'b0;
      end else if (new_two_cycle) begin
        second_pending <= 1'b1;
        saved_op       <= i_wdata[`CIRS_CMD_WORD_HI:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Device pins.
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_ce_n  <= 1'b1;
      o_cmd_n <= 1'b1;
      o_wr_n  <= 1'b1;
      o_dq    <= '0;
      o_dq_oe <= 1'b0;
    end else begin
      if (start) begin
        o_cmd_n <= !(new_kind == CIRS_CMD_WRITE || new_kind == CIRS_CMD_READ);
        o_wr_n  <= !(new_kind == CIRS_CMD_WRITE || new_kind == CIRS_DATA_WRITE);
        o_dq    <= i_wdata[`CIRS_CMD_WORD_HI:0];
        o_dq_oe <= (new_kind == CIRS_CMD_WRITE || new_kind == CIRS_DATA_WRITE);
      end else if (state == CIRS_HIGH && timer_done && !(status_pair && !status_high)) begin
        o_cmd_n <= 1'b1;
        o_wr_n  <= 1'b1;
        o_dq_oe <= 1'b0;
      end
      if (state == CIRS_SETUP) begin
        o_ce_n <= 1'b0;
      end else if (state == CIRS_LOW && timer_done) begin
        o_ce_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read capture.
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      read_word    <= '0;
      match_status <= '0;
    end else if (state == CIRS_LOW && timer_done && (kind == CIRS_CMD_READ || kind == CIRS_DATA_READ)) begin
      read_word <= i_dq;
      if (status_pair && !status_high) begin
        match_status[15:0] <= i_dq;
      end else if (status_pair) begin
        match_status[31:16] <= i_dq;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port.
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      o_rdata <= '0;
      if (is_addr(i_addr, `CIRS_OFS_CMD)) begin
        o_rdata <= {16'h0000, cur_word};
      end else if (is_addr(i_addr, `CIRS_OFS_CONFIG)) begin
        o_rdata <= {{(32-`CIRS_CFG_W){1'b0}}, config_bits};
      end else if (is_addr(i_addr, `CIRS_OFS_STATE)) begin
        o_rdata <= {28'h000_0000, cur_class, second_pending, (state != CIRS_IDLE)};
      end else if (is_addr(i_addr, `CIRS_OFS_READ_WORD)) begin
        o_rdata <= {16'h0000, read_word};
      end else if (is_addr(i_addr, `CIRS_OFS_STATUS)) begin
        o_rdata <= match_status;
      end else if (is_addr(i_addr, `CIRS_OFS_DECODE)) begin
        o_rdata <= {27'h000_0000,
                    !match_status[`CIRS_ST_HIT_N],
                    match_status[`CIRS_ST_VAL_HI:`CIRS_ST_VAL_LO],
                    !match_status[`CIRS_ST_MULTI_N],
                    !match_status[`CIRS_ST_FULL_N]};
      end
    end
  end

endmodule : cirs_host

//--- verif/cirs_host_checker.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Pin timing checks for the host controller.
// ----------------------------------------------------------------
module cirs_host_checker (
  input wire logic        i_clock,
  input wire logic        i_rstn,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_ce_n,
  input wire logic        o_cmd_n,
  input wire logic        o_wr_n,
  input wire logic        o_dq_oe
);
  logic [3:0] lo_cnt;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) lo_cnt <= 4'h0;
    else if (o_ce_n) lo_cnt <= 4'h0;
    else lo_cnt <= lo_cnt + 4'h1;
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  ce_short_min_a: assert property ($fell(o_ce_n) |-> !o_ce_n [*3]) else $error("ce low too short");
  ce_long_max_a: assert property ($fell(o_ce_n) |-> ##[1:9] o_ce_n) else $error("ce low too long");
  ce_len_legal_a: assert property ($rose(o_ce_n) |-> lo_cnt inside {4'h3, 4'h6, 4'h9})
    else $error("ce low width not a cycle class");
  ctrl_setup_a: assert property ($fell(o_ce_n) |-> $stable({o_cmd_n, o_wr_n, o_dq_oe}))
    else $error("controls changed at ce fall");
  ctrl_hold_a: assert property ((!o_ce_n || $rose(o_ce_n)) && !$fell(o_ce_n) |-> $stable({o_cmd_n, o_wr_n}))
    else $error("controls changed while ce low");
  write_drive_a: assert property (!o_ce_n && !o_wr_n |-> o_dq_oe) else $error("write without drive");
  read_release_a: assert property (!o_ce_n && o_wr_n |-> !o_dq_oe) else $error("read with drive");
  rdata_hold_a: assert property (!i_rd |=> $stable(o_rdata)) else $error("read data moved");

  cover property ($rose(o_ce_n) && lo_cnt == 4'h3);
  cover property ($rose(o_ce_n) && lo_cnt == 4'h6);
  cover property ($rose(o_ce_n) && lo_cnt == 4'h9);
  cover property ($fell(o_ce_n) && !o_cmd_n && o_wr_n);
endmodule : cirs_host_checker

bind cirs_host cirs_host_checker u_cirs_host_checker (.i_clock, .i_rstn, .i_rd, .o_rdata, .o_ce_n, .o_cmd_n,
  .o_wr_n, .o_dq_oe);

//--- verif/cirs_dev_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Device model: status pair on command reads, control register on data cycles.
// ----------------------------------------------------------------
module cirs_dev_model #(
  parameter logic [31:0] STATUS_WORD = 32'h5000_0402,
  parameter logic [15:0] CTRL_RESET  = 16'h0000
) (
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        i_ce_n,
  input  wire logic        i_cmd_n,
  input  wire logic        i_wr_n,
  input  wire logic [15:0] i_dq,
  output logic      [15:0] o_dq
);
  logic        ce_q;
  logic        upper_half;
  logic [15:0] ctrl;

  function automatic logic [1:0] merge_field(input logic [1:0] cur, input logic [1:0] nw, input logic rsv);
    merge_field = (nw == 2'h3 || (rsv && nw == 2'h2)) ? cur : nw;
  endfunction : merge_field

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      ce_q       <= 1'b1;
      upper_half <= 1'b0;
      o_dq       <= 16'h0;
      ctrl       <= {1'b0, CTRL_RESET[14:0]};
    end else begin
      ce_q <= i_ce_n;
      if (!i_ce_n && !i_cmd_n && i_wr_n) o_dq <= upper_half ? STATUS_WORD[31:16] : STATUS_WORD[15:0];
      else if (!i_ce_n && i_cmd_n && i_wr_n) o_dq <= ctrl;
      else o_dq <= ~o_dq;
      if (i_ce_n && !ce_q) upper_half <= (!i_cmd_n && i_wr_n) ? !upper_half : 1'b0;
      if (i_ce_n && !ce_q && i_cmd_n && !i_wr_n) begin
        if (!i_dq[15]) ctrl <= {1'b0, CTRL_RESET[14:0]};
        else ctrl <= {1'b0, merge_field(ctrl[14:13], i_dq[14:13], 1'b1),
                      merge_field(ctrl[12:11], i_dq[12:11], 1'b1),
                      merge_field(ctrl[10:9], i_dq[10:9], 1'b1),
                      (&i_dq[8:6]) ? ctrl[8:6] : i_dq[8:6],
                      merge_field(ctrl[5:4], i_dq[5:4], 1'b0),
                      merge_field(ctrl[3:2], i_dq[3:2], 1'b0),
                      merge_field(ctrl[1:0], i_dq[1:0], 1'b1)};
      end
    end
  end
endmodule : cirs_dev_model

//--- verif/testbench.sv
`timescale 1ns/100ps
`include "cirs_consts.svh"
module testbench import cirs_pkg::*;;
  localparam logic [31:0] STATUS_EXP = 32'h5000_0402;
  typedef struct {logic [31:0] cmd; logic [2:0] cfg; cirs_class_t cls;} cirs_row_t;
  logic i_clock, i_rstn, i_wr, i_rd, o_ce_n, o_cmd_n, o_wr_n, o_dq_oe;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, rd_val;
  logic [15:0] o_dq, dev_dq;
  int          miscompares, comparisons, cycles;
  cirs_row_t   rows[23];

  cirs_host u_cirs_host (.i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_ce_n(o_ce_n), .o_cmd_n(o_cmd_n), .o_wr_n(o_wr_n), .o_dq(o_dq),
    .o_dq_oe(o_dq_oe), .i_dq(dev_dq));
  cirs_dev_model #(.STATUS_WORD(STATUS_EXP)) u_cirs_dev_model (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_ce_n(o_ce_n), .i_cmd_n(o_cmd_n), .i_wr_n(o_wr_n), .i_dq(o_dq), .o_dq(dev_dq));

  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  task give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : reg_wr

  task reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : reg_rd

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task chk_class(input logic [1:0] got, input cirs_class_t exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: class %0d expected %0d", $time, got, exp);
    end
  endtask : chk_class

  task run_cmd(input logic [31:0] cmd, input logic [2:0] cfg, input cirs_class_t cls);
    int n;
    n = 0;
    reg_wr(`CIRS_OFS_CONFIG, {29'h0, cfg});
    reg_wr(`CIRS_OFS_CMD, cmd);
    do begin
      reg_rd(`CIRS_OFS_STATE, rd_val);
      n++;
    end while (rd_val[0] !== 1'b0 && n < 40);
    chk_word({31'h0, rd_val[0]}, 32'h0);
    chk_class(rd_val[3:2], cls);
  endtask : run_cmd

  task ctrl_rw(input logic [15:0] wr, input logic [15:0] exp);
    run_cmd({16'h0001, wr}, 3'h0, CIRS_SHORT);
    run_cmd(32'h0003_0000, 3'h0, CIRS_MEDIUM);
    reg_rd(`CIRS_OFS_READ_WORD, rd_val);
    chk_word(rd_val, {16'h0000, exp});
  endtask : ctrl_rw

  task two_cycle(input logic [31:0] op, input logic [2:0] cfg, input cirs_class_t cls);
    run_cmd(op, cfg, CIRS_SHORT);
    chk_word({31'h0, rd_val[1]}, 32'h1);
    run_cmd(32'h0, cfg, cls);
  endtask : two_cycle

  initial begin
    i_rstn = 1'b0; i_wr = 1'b0; i_rd = 1'b0; i_addr = 8'h0; i_wdata = 32'h0;
    miscompares = 0; comparisons = 0; cycles = 0;
    rows = '{'{32'h0000_0504, 3'h0, CIRS_LONG}, '{32'h0000_0505, 3'h0, CIRS_LONG}, '{32'h0000_0506, 3'h0, CIRS_LONG},
      '{32'h0000_0507, 3'h0, CIRS_LONG}, '{32'h0000_0600, 3'h0, CIRS_MEDIUM}, '{32'h0000_0601, 3'h0, CIRS_MEDIUM},
      '{32'h0000_0610, 3'h0, CIRS_MEDIUM}, '{32'h0000_0611, 3'h0, CIRS_MEDIUM}, '{32'h0000_0618, 3'h0, CIRS_SHORT},
      '{32'h0000_0619, 3'h0, CIRS_SHORT}, '{32'h0000_061A, 3'h0, CIRS_SHORT}, '{32'h0000_0700, 3'h0, CIRS_LONG},
      '{32'h0000_0301, 3'h0, CIRS_SHORT}, '{32'h0000_0301, 3'h4, CIRS_MEDIUM}, '{32'h0000_0304, 3'h0, CIRS_MEDIUM},
      '{32'h0000_0320, 3'h0, CIRS_LONG}, '{32'h0000_0424, 3'h0, CIRS_MEDIUM}, '{32'h0000_0424, 3'h1, CIRS_LONG},
      '{32'h0001_1234, 3'h0, CIRS_SHORT}, '{32'h0009_1234, 3'h0, CIRS_LONG}, '{32'h0005_1234, 3'h1, CIRS_LONG},
      '{32'h0005_1234, 3'h0, CIRS_MEDIUM}, '{32'h0007_0000, 3'h0, CIRS_LONG}};
    repeat (5) @(posedge i_clock);
    chk_word({29'h0, o_ce_n, o_dq_oe, o_rdata[0]}, 32'h4);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clock);
    reg_rd(`CIRS_OFS_CONFIG, rd_val);
    chk_word(rd_val, 32'h0);
    reg_rd(`CIRS_OFS_STATE, rd_val);
    chk_word(rd_val, 32'h0);
    $display("test reset done");
    foreach (rows[i]) run_cmd(rows[i].cmd, rows[i].cfg, rows[i].cls);
    $display("test cycle classes done");
    two_cycle(32'h0000_0200, 3'h0, CIRS_SHORT);
    two_cycle(32'h0000_0200, 3'h2, CIRS_LONG);
    two_cycle(32'h0000_0201, 3'h0, CIRS_MEDIUM);
    two_cycle(32'h0000_0C24, 3'h1, CIRS_LONG);
    $display("test two cycle done");
    run_cmd(32'h0006_0000, 3'h0, CIRS_MEDIUM);
    reg_rd(`CIRS_OFS_STATUS, rd_val);
    chk_word(rd_val, STATUS_EXP);
    reg_rd(`CIRS_OFS_DECODE, rd_val);
    chk_word(rd_val, {27'h0, ~STATUS_EXP[0], STATUS_EXP[29:28], ~STATUS_EXP[30], ~STATUS_EXP[31]});
    reg_rd(`CIRS_OFS_READ_WORD, rd_val);
    chk_word(rd_val, {16'h0000, STATUS_EXP[31:16]});
    $display("test status pair done");
    ctrl_rw(16'hB3E6, 16'h2224);
    ctrl_rw(16'hFFFF, 16'h2224);
    ctrl_rw(16'h0000, 16'h0000);
    $display("test control register done");
    reg_wr(`CIRS_OFS_CMD, 32'h0000_0504);
    run_cmd(32'h0000_0600, 3'h0, CIRS_LONG);
    reg_rd(`CIRS_OFS_CMD, rd_val);
    chk_word(rd_val, 32'h0000_0504);
    reg_wr(8'h20, 32'hFFFF_FFFF);
    reg_rd(8'h20, rd_val);
    chk_word(rd_val, 32'h0);
    $display("test busy and unmapped done");
    give_verdict();
  end
endmodule : testbench
